// [hdl/fllm_pkg.sv]
// Behaviour
// - during flash reset, load nonvolatile lock word into volatile lock register
// - nonvolatile word is 64 bits; upper 32 bits only carry ecc
// - lock enable flag is read-only; writing its bit does nothing
// - writing 0xa1a11111 to the lock register sets the lock enable flag
// - lock enable flag stays set until the next reset
// - test/shadow, mid and low lock bits writable only while enable set
// - test/shadow lock at 1 blocks program and erase of that space
// - test block is never erased regardless of lock bit
// - after interlock write, test/shadow lock writes ignored until done sets
// - test/shadow lock writes ignored while high-voltage operation suspended
// - every reset restores test/shadow lock from test sector; writable between resets
// - erased nonvolatile source makes test/shadow lock come out locked
// - test/shadow lock write only permitted when lock enable flag is high
// - test/shadow space modifiable only when primary and secondary locks are 0
// - effective lock of each block is primary or secondary lock
package fllm_pkg;

   // -------------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------------
   localparam logic [3:0]  ADDR_LOCK    = 4'h0;
   localparam logic [3:0]  ADDR_SECLOCK = 4'h4;
   localparam logic [3:0]  ADDR_STATUS  = 4'h8;
   localparam logic [31:0] LOCK_PASSWORD = 32'ha1a11111;

   // -------------------------------------------------------------------------
   // lock register fields
   // -------------------------------------------------------------------------
   localparam int POS_ENABLE = 31;
   localparam int POS_TSLOCK = 20;
   localparam int POS_MIDLO  = 16;
   localparam int MID_W      = 2;
   localparam int LOW_W      = 16;
   localparam int LOW_USED   = 6;
   localparam logic [63:0] NV_ERASED = 64'hffffffffffffffff;

   // -------------------------------------------------------------------------
   // load sequence states
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_REQ  = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } fllm_state_e;

   typedef struct packed {
      logic             tsLock;
      logic [MID_W-1:0] midLock;
      logic [LOW_W-1:0] lowLock;
   } fllm_locks_s;

   typedef struct packed {
      fllm_state_e state;
      logic        enable;
      fllm_locks_s prim;
      fllm_locks_s sec;
      logic        interlockHold;
      logic        nvReq;
      logic [31:0] rdData;
      fllm_locks_s effLock;
      logic        tsProgOk;
      logic        tsEraseOk;
      logic        loaded;
   } fllm_state_s;

endpackage

// [hdl/fllm_lock.sv]
`timescale 1ns/1ps
`default_nettype none
module fllm_lock
   import fllm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   output logic             nvReadReq,
   input  wire logic        nvReadValid,
   input  wire logic [63:0] nvLockWord,
   input  wire logic [63:0] nvSecLockWord,
   input  wire logic        interlockDone,
   input  wire logic        opDone,
   input  wire logic        hvSuspended,
   output fllm_locks_s      effLockOut,
   output logic             tsProgramAllow,
   output logic             tsEraseAllow,
   output logic             locksLoaded
);

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   fllm_state_s s_q;
   fllm_state_s s_d;
   fllm_locks_s nvPrim;
   fllm_locks_s nvSec;
   fllm_locks_s wrLocks;
   logic        lockWr;
   logic        pwMatch;
   logic        tsWrOk;

   // gather the lock fields out of a 32-bit register image
   function automatic fllm_locks_s pickLocks(input logic [31:0] w);
      pickLocks = {w[POS_TSLOCK], w[POS_MIDLO +: MID_W], w[LOW_W-1:0]};
   endfunction

   // only the low 32 bits carry locks; upper half is ecc only
   assign nvPrim  = pickLocks(nvLockWord[31:0]);
   assign nvSec   = pickLocks(nvSecLockWord[31:0]);
   assign wrLocks = pickLocks(regWdata);
   assign lockWr  = regWr && (regAddr == ADDR_LOCK);
   assign pwMatch = (regWdata == LOCK_PASSWORD);
   assign tsWrOk  = s_q.enable && !s_q.interlockHold && !hvSuspended;

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.nvReq = 1'b0;
      case (s_q.state)
         ST_REQ: begin
            s_d.nvReq = 1'b1;
            s_d.state = ST_WAIT;
         end
         ST_WAIT: begin
            s_d.nvReq = 1'b1;
            if (nvReadValid) begin
               // erased word reads all ones, so every lock comes out set
               s_d.prim = nvPrim;
               s_d.prim.lowLock[LOW_W-1:LOW_USED] = '1;
               s_d.sec = nvSec;
               s_d.sec.lowLock[LOW_W-1:LOW_USED] = '1;
               s_d.nvReq = 1'b0;
               s_d.loaded = 1'b1;
               s_d.state = ST_RUN;
            end
         end
         ST_RUN: begin
            // a new interlock in the cycle of done must not be lost, so set wins
            if (opDone) begin
               s_d.interlockHold = 1'b0;
            end
            if (interlockDone) begin
               s_d.interlockHold = 1'b1;
            end
            if (lockWr) begin
               if (pwMatch) begin
                  s_d.enable = 1'b1;
               end else if (s_q.enable) begin
                  // bit 31 is status only, the write value is dropped
                  if (tsWrOk) begin
                     s_d.prim.tsLock = wrLocks.tsLock;
                  end
                  if (!s_q.interlockHold && !hvSuspended) begin
                     s_d.prim.midLock = wrLocks.midLock;
                     s_d.prim.lowLock[LOW_USED-1:0] = wrLocks.lowLock[LOW_USED-1:0];
                  end
               end
            end
            if (regWr && (regAddr == ADDR_SECLOCK) && !s_q.interlockHold
                && !hvSuspended) begin
               // secondary lock may only be raised here, never lowered
               s_d.sec = s_q.sec | pickLocks(regWdata);
            end
         end
         default: begin
            s_d.state = ST_REQ;
         end
      endcase
      s_d.effLock   = s_d.prim | s_d.sec;
      s_d.tsProgOk  = s_d.loaded && !s_d.effLock.tsLock;
      s_d.tsEraseOk = 1'b0;
      s_d.rdData = '0;
      if (regRd) begin
         case (regAddr)
            ADDR_LOCK:    s_d.rdData = {s_q.enable, 10'h000, s_q.prim.tsLock, 2'h0,
                                        s_q.prim.midLock, s_q.prim.lowLock};
            ADDR_SECLOCK: s_d.rdData = {11'h000, s_q.sec.tsLock, 2'h0,
                                        s_q.sec.midLock, s_q.sec.lowLock};
            ADDR_STATUS:  s_d.rdData = {28'h0000000, s_q.tsProgOk, s_q.interlockHold,
                                        hvSuspended, s_q.loaded};
            default:      s_d.rdData = 32'h00000000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_q.state         <= ST_REQ;
         s_q.enable        <= 1'b0;
         s_q.prim          <= '1;
         s_q.sec           <= '1;
         s_q.interlockHold <= 1'b0;
         s_q.nvReq         <= 1'b0;
         s_q.rdData        <= 32'h00000000;
         s_q.effLock       <= '1;
         s_q.tsProgOk      <= 1'b0;
         s_q.tsEraseOk     <= 1'b0;
         s_q.loaded        <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign regRdata       = s_q.rdData;
   assign nvReadReq      = s_q.nvReq;
   assign effLockOut     = s_q.effLock;
   assign tsProgramAllow = s_q.tsProgOk;
   assign tsEraseAllow   = s_q.tsEraseOk;
   assign locksLoaded    = s_q.loaded;

endmodule
`default_nettype wire

// [verif/fllm_lock_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module fllm_lock_sva import fllm_pkg::*; (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic [3:0]  regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdata,
   input wire logic        nvReadReq,
   input wire logic        nvReadValid,
   input wire logic [63:0] nvLockWord,
   input wire logic [63:0] nvSecLockWord,
   input wire logic        interlockDone,
   input wire logic        opDone,
   input wire logic        hvSuspended,
   input wire fllm_locks_s effLockOut,
   input wire logic        tsProgramAllow,
   input wire logic        tsEraseAllow,
   input wire logic        locksLoaded
);
   // ---------------------------------------------
   // shadow of enable and hold, set wins
   // ---------------------------------------------
   logic enSeen_q;
   logic hold_q;
   wire lockWr = regWr && regAddr == ADDR_LOCK;
   always_ff @(posedge mclk) begin
      enSeen_q <= !sys_rst && (enSeen_q || (lockWr && regWdata == LOCK_PASSWORD && locksLoaded));
      hold_q   <= !sys_rst && (interlockDone || (hold_q && !opDone));
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   load_wait_a: assert property (nvReadReq && !nvReadValid |=> nvReadReq)
      else $error("load request dropped early");
   load_ts_a: assert property (nvReadReq && nvReadValid |=>
      effLockOut.tsLock == $past(nvLockWord[POS_TSLOCK] | nvSecLockWord[POS_TSLOCK]))
      else $error("lock not loaded");
   locked_wr_a: assert property (lockWr && !enSeen_q |=> $stable(effLockOut))
      else $error("lock changed while disabled");
   en_read_a: assert property (regRd && regAddr == ADDR_LOCK |=>
      regRdata[POS_ENABLE] == $past(enSeen_q)) else $error("enable flag wrong");
   ts_hold_a: assert property (lockWr && (hold_q || hvSuspended) |=> $stable(effLockOut.tsLock))
      else $error("lock written during hold");
   prog_allow_a: assert property (tsProgramAllow == (locksLoaded && !effLockOut.tsLock))
      else $error("program allow wrong");
   never_erase_a: assert property (!tsEraseAllow)
      else $error("erase allowed");
   low_fixed_a: assert property (effLockOut.lowLock[15:6] == 10'h3ff)
      else $error("unused low locks not set");
   cover property (lockWr && regWdata == LOCK_PASSWORD);
   cover property (lockWr && hold_q);
   cover property (tsProgramAllow);
endmodule
bind fllm_lock fllm_lock_sva i_fllm_lock_sva (.*);
`default_nettype wire

// [verif/fllm_lock_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fllm_lock_tb_top import fllm_pkg::*; ;
   logic mclk = 0, sys_rst = 1, regWr = 0, regRd = 0, nvReadValid = 0;
   logic interlockDone = 0, opDone = 0, hvSuspended = 0;
   logic [3:0] regAddr = 0;
   logic [31:0] regWdata = 0, regRdata, q;
   logic [63:0] nvLockWord = 0, nvSecLockWord = 0;
   logic nvReadReq, tsProgramAllow, tsEraseAllow, locksLoaded;
   fllm_locks_s effLockOut, e;
   int errTotal = 0, nTests = 0, k;
   fllm_lock i_fllm_lock (.*);
   initial forever #20 mclk = ~mclk;
   // ---------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------
   task chk(input string s, input logic [31:0] x, input logic [31:0] y);
      nTests++;
      if (x !== y) begin
         errTotal++;
         $display("wrong value %s exp %h got %h", s, x, y);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge mclk) regWr <= 1'h0;
      @(posedge mclk);
   endtask
   task rd(input logic [3:0] a);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge mclk) regRd <= 1'h0;
      @(posedge mclk) q = regRdata;
   endtask
   task tally_and_finish;
      $display("tests %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // full reset, then the load handshake under a bound
   task rst(input logic [63:0] p, input logic [63:0] s);
      sys_rst <= 1'h1;
      nvLockWord <= p;
      nvSecLockWord <= s;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'h0;
      for (k = 0; k < 50 && nvReadReq !== 1'h1; k++) @(posedge mclk);
      if (nvReadReq !== 1'h1) begin
         errTotal++;
         tally_and_finish;
      end
      nvReadValid <= 1'h1;
      @(posedge mclk) nvReadValid <= 1'h0;
      for (k = 0; k < 50 && locksLoaded !== 1'h1; k++) @(posedge mclk);
      if (locksLoaded !== 1'h1) begin
         errTotal++;
         tally_and_finish;
      end
   endtask
   function automatic fllm_locks_s ex(input logic [63:0] p, input logic [63:0] s);
      return {p[20] | s[20], p[17:16] | s[17:16], 10'h3ff, p[5:0] | s[5:0]};
   endfunction
   initial begin
      k = $urandom(52);
      rst({$urandom, $urandom}, 64'h0);
      chk("load", ex(nvLockWord, nvSecLockWord), effLockOut);
      chk("prog", !nvLockWord[POS_TSLOCK], tsProgramAllow);
      e = effLockOut;
      wr(ADDR_LOCK, $urandom & 32'hfffffffe);
      wr(ADDR_LOCK, LOCK_PASSWORD ^ 32'h100);
      chk("locked", e, effLockOut);
      rd(ADDR_LOCK);
      chk("en0", 0, q[31]);
      $display("locked test done");
      wr(ADDR_LOCK, LOCK_PASSWORD);
      rd(ADDR_LOCK);
      chk("en1", 1, q[31]);
      wr(ADDR_LOCK, 32'h0);
      chk("clear", 19'h0ffc0, effLockOut);
      rd(ADDR_LOCK);
      chk("lockrd", 32'h8000ffc0, q);
      chk("prog1", 1, tsProgramAllow);
      wr(ADDR_SECLOCK, 32'h10000);
      chk("or", 19'h1ffc0, effLockOut);
      rd(ADDR_SECLOCK);
      chk("secrd", 32'h0001ffc0, q);
      hvSuspended <= 1'h1;
      wr(ADDR_LOCK, 32'h100000);
      chk("susp", 0, effLockOut.tsLock);
      hvSuspended <= 1'h0;
      interlockDone <= 1'h1;
      @(posedge mclk) interlockDone <= 1'h0;
      rd(ADDR_STATUS);
      chk("status", 32'hd, q);
      wr(ADDR_LOCK, 32'h100000);
      chk("hold", 0, effLockOut.tsLock);
      opDone <= 1'h1;
      @(posedge mclk) opDone <= 1'h0;
      wr(ADDR_LOCK, 32'h100000);
      chk("done", 1, effLockOut.tsLock);
      chk("prog2", 0, tsProgramAllow);
      chk("erase", 0, tsEraseAllow);
      $display("write test done");
      rst(NV_ERASED, 64'h0);
      chk("erased", 19'h7ffff, effLockOut);
      rd(ADDR_LOCK);
      chk("en2", 0, q[31]);
      $display("reset test done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
